//--- logic/flash_status_config_regs.sv
`timescale 1ns/1ps
module flash_status_config_regs (
    // system
    input wire logic i_mclk,
    input wire logic i_srst,
    // serial link
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    // pins
    input wire logic i_wp_n,
    input wire logic i_dev_rst_n,
    // array engine
    input wire logic i_array_busy,
    input wire logic i_array_req,
    input wire logic i_array_overlap,
    output logic o_array_go,
    output logic o_block_lock_preset,
    // status and configuration
    output logic o_busy,
    output logic o_write_enable_latch,
    output logic [3:0] o_protect_range_bits,
    output logic o_top_bottom_select,
    output logic o_complement_protect,
    output logic o_protect_scheme_select,
    output logic o_quad_enable_bit,
    output logic [2:0] o_secure_area_lock_bits,
    output logic o_pause_state_flag,
    output logic o_current_addr_width,
    output logic o_powerup_addr_width,
    output logic [1:0] o_output_drive_level
);
    typedef struct packed {
        logic link_rst;
        logic cs_prev;
        logic tgl_prev;
        logic rst_prev;
        logic snap_req;
        logic [23:0] snap;
        logic [7:0] cmd;
        logic [7:0] data;
        logic [1:0] byte_cnt;
        logic [1:0] prefix;
        logic busy_sr;
        logic [8:0] busy_cnt;
        logic busy;
        logic write_enable_latch;
        logic [3:0] bp;
        logic tb;
        logic status_guard_bit;
        logic status_lockdown_bit;
        logic otp;
        logic qe;
        logic [2:0] lb;
        logic cmp;
        logic pause_state_flag;
        logic current_addr_width;
        logic powerup_addr_width;
        logic protect_scheme_select;
        logic [1:0] drv;
        logic go;
        logic preset;
    } core_t;

    core_t r;
    core_t nxt;

    spi_link_if lk ();

    logic [4:0] sync_q;
    logic cs_s;
    logic wp_s;
    logic rst_s;
    logic tgl_s;
    logic ack_s;

    // pins and link-side flags all cross on two flops
    cdc_sync #(
        .W(5)
    ) u_sync (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_d({i_cs_n, i_wp_n, i_dev_rst_n, lk.byte_tgl, lk.snap_ack}),
        .o_q(sync_q)
    );

    assign cs_s = sync_q[4];
    assign wp_s = sync_q[3];
    assign rst_s = sync_q[2];
    assign tgl_s = sync_q[1];
    assign ack_s = sync_q[0];

    spi_link_rx u_link (
        .i_sclk(i_sclk),
        .i_cs_n(i_cs_n),
        .i_mosi(i_mosi),
        .o_miso(o_miso),
        .o_miso_oe(o_miso_oe),
        .lk(lk.link)
    );

    // three register bytes as the host reads them; reserved bits are zero
    function automatic logic [23:0] status_of(input core_t s);
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
        b1 = 8'h00;
        b2 = 8'h00;
        b3 = 8'h00;
        b1[flash_regs_pkg::B1_BUSY] = s.busy;
        b1[flash_regs_pkg::B1_WEL] = s.write_enable_latch;
        b1[flash_regs_pkg::B1_BP_LO +: 4] = s.bp;
        b1[flash_regs_pkg::B1_TB] = s.tb;
        b1[flash_regs_pkg::B1_SRP] = s.status_guard_bit;
        b2[flash_regs_pkg::B2_SRL] = s.status_lockdown_bit;
        b2[flash_regs_pkg::B2_QE] = s.qe;
        b2[flash_regs_pkg::B2_LB_LO +: 3] = s.lb;
        b2[flash_regs_pkg::B2_CMP] = s.cmp;
        b2[flash_regs_pkg::B2_SUS] = s.pause_state_flag;
        b3[flash_regs_pkg::B3_ADS] = s.current_addr_width;
        b3[flash_regs_pkg::B3_ADP] = s.powerup_addr_width;
        b3[flash_regs_pkg::B3_WPS] = s.protect_scheme_select;
        b3[flash_regs_pkg::B3_DRV_LO +: 2] = s.drv;
        status_of = {b3, b2, b1};
    endfunction

    always_comb begin
        logic busy_now;
        logic new_byte;
        logic cs_rise;
        logic wr_ok;
        busy_now = r.busy_sr | i_array_busy;
        new_byte = (tgl_s != r.tgl_prev);
        cs_rise = cs_s & ~r.cs_prev;
        // lockdown or permanent lock beats everything, then guard with pin
        wr_ok = r.write_enable_latch & ~r.status_lockdown_bit & ~r.otp & ~(r.status_guard_bit & ~wp_s);

        nxt = r;
        nxt.link_rst = 1'b0;
        nxt.go = 1'b0;
        nxt.preset = 1'b0;
        nxt.cs_prev = cs_s;
        nxt.tgl_prev = tgl_s;
        nxt.rst_prev = rst_s;
        nxt.busy = busy_now;

        // status write timer
        if (r.busy_sr) begin
            if (r.busy_cnt == 9'h000) begin
                nxt.busy_sr = 1'b0;
            end else begin
                nxt.busy_cnt = r.busy_cnt - 9'h001;
            end
        end

        // byte collection
        if (new_byte) begin
            if (r.byte_cnt == 2'h0) begin
                nxt.cmd = lk.rx_byte;
            end
            if (r.byte_cnt == 2'h1) begin
                nxt.data = lk.rx_byte;
            end
            if (r.byte_cnt != 2'h3) begin
                nxt.byte_cnt = r.byte_cnt + 2'h1;
            end
        end

        // instructions take effect when chip select rises
        if (cs_rise && r.byte_cnt != 2'h0) begin
            nxt.byte_cnt = 2'h0;
            if (r.cmd != flash_regs_pkg::OP_PREFIX1 && r.cmd != flash_regs_pkg::OP_PREFIX2) begin
                nxt.prefix = 2'h0;
            end
            if (busy_now) begin
                // only suspend gets through; reads are served by the link, not here
                if (r.cmd == flash_regs_pkg::OP_SUSPEND) begin
                    nxt.pause_state_flag = 1'b1;
                end
            end else begin
                unique case (r.cmd)
                    flash_regs_pkg::OP_WREN: begin
                        nxt.write_enable_latch = 1'b1;
                    end
                    flash_regs_pkg::OP_WRDI: begin
                        nxt.write_enable_latch = 1'b0;
                    end
                    flash_regs_pkg::OP_RESUME: begin
                        nxt.pause_state_flag = 1'b0;
                    end
                    flash_regs_pkg::OP_ENTER4: begin
                        nxt.current_addr_width = 1'b1;
                    end
                    flash_regs_pkg::OP_EXIT4: begin
                        nxt.current_addr_width = 1'b0;
                    end
                    flash_regs_pkg::OP_PREFIX1: begin
                        nxt.prefix = 2'h1;
                    end
                    flash_regs_pkg::OP_PREFIX2: begin
                        nxt.prefix = (r.prefix == 2'h1) ? 2'h2 : 2'h0;
                    end
                    flash_regs_pkg::OP_WR1: begin
                        if (wr_ok && r.byte_cnt != 2'h1) begin
                            nxt.bp = r.data[flash_regs_pkg::B1_BP_LO +: 4];
                            nxt.tb = r.data[flash_regs_pkg::B1_TB];
                            nxt.status_guard_bit = r.data[flash_regs_pkg::B1_SRP];
                            nxt.write_enable_latch = 1'b0;
                            nxt.busy_sr = 1'b1;
                            nxt.busy_cnt = flash_regs_pkg::SR_WRITE_CNT;
                        end
                    end
                    flash_regs_pkg::OP_WR2: begin
                        if (wr_ok && r.byte_cnt != 2'h1) begin
                            nxt.status_lockdown_bit = r.data[flash_regs_pkg::B2_SRL];
                            // otp flag is set only behind the prefix pair; i_srst clears it along with lockdown
                            nxt.otp = (r.prefix == 2'h2) & r.data[flash_regs_pkg::B2_SRL];
                            nxt.qe = r.data[flash_regs_pkg::B2_QE];
                            // set-only: a zero written never unlocks an area
                            nxt.lb = r.lb | r.data[flash_regs_pkg::B2_LB_LO +: 3];
                            nxt.cmp = r.data[flash_regs_pkg::B2_CMP];
                            nxt.write_enable_latch = 1'b0;
                            nxt.busy_sr = 1'b1;
                            nxt.busy_cnt = flash_regs_pkg::SR_WRITE_CNT;
                        end
                    end
                    flash_regs_pkg::OP_WR3: begin
                        if (wr_ok && r.byte_cnt != 2'h1) begin
                            nxt.powerup_addr_width = r.data[flash_regs_pkg::B3_ADP];
                            nxt.protect_scheme_select = r.data[flash_regs_pkg::B3_WPS];
                            nxt.drv = r.data[flash_regs_pkg::B3_DRV_LO +: 2];
                            nxt.write_enable_latch = 1'b0;
                            nxt.busy_sr = 1'b1;
                            nxt.busy_cnt = flash_regs_pkg::SR_WRITE_CNT;
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end else if (cs_s) begin
            nxt.byte_cnt = 2'h0;
        end

        // array program or erase request from the engine
        if (i_array_req && !busy_now && r.write_enable_latch) begin
            if (!i_array_overlap) begin
                nxt.go = 1'b1;
                nxt.write_enable_latch = 1'b0;
            end
        end

        // device reset pin: volatile state reloads, lockdown survives
        if (!rst_s && r.rst_prev) begin
            nxt.write_enable_latch = 1'b0;
            nxt.pause_state_flag = 1'b0;
            nxt.busy_sr = 1'b0;
            nxt.current_addr_width = r.powerup_addr_width;
            nxt.preset = 1'b1;
            nxt.byte_cnt = 2'h0;
            nxt.prefix = 2'h0;
            nxt.link_rst = 1'b1;
        end

        // publish a fresh snapshot whenever the link has taken the last one
        if (r.snap_req == ack_s) begin
            nxt.snap = status_of(r);
            nxt.snap_req = ~r.snap_req;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= '0;
            r.link_rst <= 1'b1;
            r.cs_prev <= 1'b1;
            r.rst_prev <= 1'b1;
            r.bp <= flash_regs_pkg::BP_RESET;
            r.drv <= flash_regs_pkg::DRV_RESET;
            r.powerup_addr_width <= flash_regs_pkg::ADP_RESET;
            r.current_addr_width <= flash_regs_pkg::ADP_RESET;
            r.preset <= 1'b1;
        end else begin
            r <= nxt;
        end
    end

    assign lk.link_rst = r.link_rst;
    assign lk.snap = r.snap;
    assign lk.snap_req = r.snap_req;

    assign o_busy = r.busy;
    assign o_write_enable_latch = r.write_enable_latch;
    assign o_protect_range_bits = r.bp;
    assign o_top_bottom_select = r.tb;
    assign o_complement_protect = r.cmp;
    assign o_protect_scheme_select = r.protect_scheme_select;
    assign o_quad_enable_bit = r.qe;
    assign o_secure_area_lock_bits = r.lb;
    assign o_pause_state_flag = r.pause_state_flag;
    assign o_current_addr_width = r.current_addr_width;
    assign o_powerup_addr_width = r.powerup_addr_width;
    assign o_output_drive_level = r.drv;
    assign o_array_go = r.go;
    assign o_block_lock_preset = r.preset;
endmodule

//--- logic/flash_regs_pkg.sv
// Functional notes
// - busy flag S0 during program, erase, writes
// - busy ignores all but reads, suspend
// - busy clears when operation finishes
// - write enable latch S1 set by 06h
// - latch cleared at reset, disable, ops
// - protect range bits S5..S2 default 0
// - top_bottom select 0 top, 1 bottom
// - complement bit S14 inverts protected region
// - guard and lockdown clear: latch gates writes
// - guard set, wp low: reject writes
// - guard set, wp high: latch gates writes
// - lockdown set rejects writes until power cycle
// - prefix AAh 55h makes lock permanent; code clears it on i_srst, same as lockdown
// - pause flag S15 set 75h, cleared 7Ah
// - secure area locks S13..S11 set-only
// - quad enable S9 selects hold or quad
// - current address width read-only, register three
// - power-up width sampled at reset, written 06h+11h
// - scheme select chooses range or block locks
// - two-bit drive level, default 11
// - reserved bits read zero, writes ignored
// - power-up width S17, current width S16
// - width changes on B7h, E9h and reset pin reload
// - array ops hitting protected area ignored
package flash_regs_pkg;
    // opcodes
    localparam logic [7:0] OP_WREN = 8'h06;
    localparam logic [7:0] OP_WRDI = 8'h04;
    localparam logic [7:0] OP_RD1 = 8'h05;
    localparam logic [7:0] OP_RD2 = 8'h35;
    localparam logic [7:0] OP_RD3 = 8'h15;
    localparam logic [7:0] OP_WR1 = 8'h01;
    localparam logic [7:0] OP_WR2 = 8'h31;
    localparam logic [7:0] OP_WR3 = 8'h11;
    localparam logic [7:0] OP_SUSPEND = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;
    localparam logic [7:0] OP_ENTER4 = 8'hB7;
    localparam logic [7:0] OP_EXIT4 = 8'hE9;
    localparam logic [7:0] OP_PREFIX1 = 8'hAA;
    localparam logic [7:0] OP_PREFIX2 = 8'h55;
    // bit positions inside each register byte
    localparam int B1_BUSY = 0;
    localparam int B1_WEL = 1;
    localparam int B1_BP_LO = 2;
    localparam int B1_TB = 6;
    localparam int B1_SRP = 7;
    localparam int B2_SRL = 0;
    localparam int B2_QE = 1;
    localparam int B2_LB_LO = 3;
    localparam int B2_CMP = 6;
    localparam int B2_SUS = 7;
    localparam int B3_ADS = 0;
    localparam int B3_ADP = 1;
    localparam int B3_WPS = 2;
    localparam int B3_DRV_LO = 5;
    // values after power-up
    localparam logic [3:0] BP_RESET = 4'h0;
    localparam logic [1:0] DRV_RESET = 2'h3;
    localparam logic ADP_RESET = 1'b0;
    // status write time and cycle count
    localparam int CLK_MHZ = 40;
    localparam int SR_WRITE_TIME_US = 10;
    localparam int SR_WRITE_CYC = SR_WRITE_TIME_US * CLK_MHZ;
    localparam logic [8:0] SR_WRITE_CNT = SR_WRITE_CYC[8:0];
endpackage

//--- logic/spi_link_if.sv
`timescale 1ns/1ps
interface spi_link_if;
    logic link_rst;
    logic byte_tgl;
    logic [7:0] rx_byte;
    logic [23:0] snap;
    logic snap_req;
    logic snap_ack;
    modport core (output link_rst, output snap, output snap_req,
                  input byte_tgl, input rx_byte, input snap_ack);
    modport link (input link_rst, input snap, input snap_req,
                  output byte_tgl, output rx_byte, output snap_ack);
endinterface

//--- logic/cdc_sync.sv
`timescale 1ns/1ps
module cdc_sync #(
    parameter int W = 1
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t r;
    sync_t nxt;

    always_comb begin
        nxt = r;
        nxt.s1 = i_d;
        nxt.s2 = r.s1;
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            r <= '1;
        end else begin
            r <= nxt;
        end
    end

    assign o_q = r.s2;
endmodule

//--- logic/spi_link_rx.sv
`timescale 1ns/1ps
module spi_link_rx (
    // serial pins
    input wire logic i_sclk,
    input wire logic i_cs_n,
    input wire logic i_mosi,
    output logic o_miso,
    output logic o_miso_oe,
    // core side
    spi_link_if.link lk
);
    // frame state, cleared by chip select high since the clock stops then
    typedef struct packed {
        logic [2:0] bit_cnt;
        logic [6:0] shin;
        logic cmd_done;
        logic [1:0] sel;
        logic [6:0] tx;
        logic miso;
        logic oe;
    } frame_t;

    // state that outlives a frame
    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic ack;
        logic tgl;
        logic [7:0] rx;
        logic [23:0] copy;
    } keep_t;

    frame_t fr_r;
    frame_t fr_nxt;
    keep_t kp_r;
    keep_t kp_nxt;

    function automatic logic [1:0] sel_of(input logic [7:0] op);
        sel_of = 2'h0;
        if (op == flash_regs_pkg::OP_RD1) sel_of = 2'h1;
        if (op == flash_regs_pkg::OP_RD2) sel_of = 2'h2;
        if (op == flash_regs_pkg::OP_RD3) sel_of = 2'h3;
    endfunction

    function automatic logic [7:0] byte_of(input logic [23:0] s, input logic [1:0] sel);
        byte_of = 8'h00;
        if (sel == 2'h1) byte_of = s[7:0];
        if (sel == 2'h2) byte_of = s[15:8];
        if (sel == 2'h3) byte_of = s[23:16];
    endfunction

    always_comb begin
        logic [7:0] full;
        logic [1:0] sel;
        logic [7:0] ob;
        full = {fr_r.shin, i_mosi};
        sel = fr_r.cmd_done ? fr_r.sel : sel_of(full);
        ob = byte_of(kp_r.copy, sel);
        fr_nxt = fr_r;
        kp_nxt = kp_r;
        fr_nxt.bit_cnt = fr_r.bit_cnt + 3'h1;
        fr_nxt.shin = full[6:0];
        if (fr_r.bit_cnt == 3'h7) begin
            fr_nxt.cmd_done = 1'b1;
            fr_nxt.sel = sel;
            // same register again every byte while clocks keep coming
            fr_nxt.miso = ob[7];
            fr_nxt.tx = ob[6:0];
            fr_nxt.oe = (sel != 2'h0);
            kp_nxt.rx = full;
            kp_nxt.tgl = ~kp_r.tgl;
        end else begin
            fr_nxt.miso = fr_r.tx[6];
            fr_nxt.tx = {fr_r.tx[5:0], 1'b0};
        end
        // snapshot handshake from the core
        kp_nxt.req_s1 = lk.snap_req;
        kp_nxt.req_s2 = kp_r.req_s1;
        if (kp_r.req_s2 != kp_r.ack) begin
            kp_nxt.copy = lk.snap;
            kp_nxt.ack = kp_r.req_s2;
        end
    end

    always_ff @(posedge i_sclk or posedge i_cs_n) begin
        if (i_cs_n) begin
            fr_r <= '0;
        end else begin
            fr_r <= fr_nxt;
        end
    end

    always_ff @(posedge i_sclk or posedge lk.link_rst) begin
        if (lk.link_rst) begin
            kp_r <= '0;
        end else begin
            kp_r <= kp_nxt;
        end
    end

    assign o_miso = fr_r.miso;
    assign o_miso_oe = fr_r.oe;
    assign lk.byte_tgl = kp_r.tgl;
    assign lk.rx_byte = kp_r.rx;
    assign lk.snap_ack = kp_r.ack;
endmodule

//--- test/flash_regs_asserts.sv
`timescale 1ns/1ps
module flash_regs_asserts (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_srst,
    // array engine
    input wire logic i_array_busy,
    input wire logic i_array_req,
    input wire logic i_array_overlap,
    input wire logic o_array_go,
    // status
    input wire logic o_busy,
    input wire logic o_write_enable_latch,
    input wire logic [3:0] o_protect_range_bits,
    input wire logic o_quad_enable_bit,
    input wire logic [2:0] o_secure_area_lock_bits,
    input wire logic [1:0] o_output_drive_level
);
    localparam int WR_LO = 400;
    localparam int WR_HI = 401;
    logic [9:0] busy_cnt_r;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // one write at a time, so ten bits never wrap
    always_ff @(posedge i_mclk) begin
        if (i_srst || !o_busy) begin
            busy_cnt_r <= 10'h000;
        end else begin
            busy_cnt_r <= busy_cnt_r + 10'h001;
        end
    end
    sequence s_req_ok;
        i_array_req && o_write_enable_latch && !o_busy && !i_array_busy && !i_array_overlap;
    endsequence
    sequence s_cfg_frozen;
        $stable(o_protect_range_bits) && $stable(o_quad_enable_bit)
            && $stable(o_output_drive_level);
    endsequence
    a_req_gives_go: assert property (s_req_ok |=> o_array_go)
        else $error("accepted request gave no go pulse");
    a_go_needs_cause: assert property (o_array_go |-> $past(i_array_req)
        && $past(o_write_enable_latch) && !$past(i_array_overlap))
        else $error("go pulse without valid request");
    a_overlap_blocks_go: assert property (i_array_req && i_array_overlap |=> !o_array_go)
        else $error("protected target was started");
    a_go_clears_latch: assert property (o_array_go |-> !o_write_enable_latch)
        else $error("latch kept after array start");
    a_reset_values: assert property ($fell(i_srst) |-> o_output_drive_level == 2'h3
        && o_protect_range_bits == 4'h0 && !o_write_enable_latch && !o_busy)
        else $error("wrong value after reset");
    a_busy_follows_array: assert property (i_array_busy |=> o_busy)
        else $error("busy missing during array operation");
    a_write_time: assert property ($fell(o_busy) && !$past(i_array_busy, 2)
        |-> busy_cnt_r >= WR_LO && busy_cnt_r <= WR_HI)
        else $error("status write busy time wrong");
    a_locks_set_only: assert property (($past(o_secure_area_lock_bits)
        & ~o_secure_area_lock_bits) == 3'h0)
        else $error("secure lock bit cleared");
    a_busy_freezes_cfg: assert property (o_busy && $past(o_busy) |-> s_cfg_frozen)
        else $error("configuration changed while busy");
endmodule

bind flash_status_config_regs flash_regs_asserts flash_regs_asserts_i (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_array_busy(i_array_busy),
    .i_array_req(i_array_req), .i_array_overlap(i_array_overlap), .o_array_go(o_array_go),
    .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
    .o_protect_range_bits(o_protect_range_bits), .o_quad_enable_bit(o_quad_enable_bit),
    .o_secure_area_lock_bits(o_secure_area_lock_bits),
    .o_output_drive_level(o_output_drive_level)
);

//--- test/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
    // serial pins
    output logic o_sclk,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso
);
    initial begin
        o_sclk = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end
    // mode 0: clock rests low outside frames
    task automatic frame(input logic [23:0] tx, input int nbits, output logic [15:0] rx);
        rx = 16'h0000;
        o_cs_n = 1'b0;
        #62.5;
        for (int i = 0; i < nbits; i++) begin
            o_mosi = tx[23 - i];
            #62.5;
            o_sclk = 1'b1;
            #31.0;
            if (i >= 7 && i < 23) begin
                rx[22 - i] = i_miso;
            end
            #31.5;
            o_sclk = 1'b0;
        end
        #62.5;
        o_cs_n = 1'b1;
        o_mosi = ~o_mosi;
        // gap covers the core's sync of the frame end
        #300;
    endtask
endmodule

//--- test/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic i_mclk;
    logic i_srst;
    logic i_wp_n;
    logic i_dev_rst_n;
    logic i_array_busy;
    logic i_array_req;
    logic i_array_overlap;
    logic [15:0] rx;
    int err_count;
    int compares;
    wire sclk;
    wire cs_n;
    wire mosi;
    wire miso;
    wire o_array_go, o_busy, o_write_enable_latch, o_top_bottom_select, o_complement_protect;
    wire o_protect_scheme_select, o_quad_enable_bit, o_pause_state_flag;
    wire o_current_addr_width, o_powerup_addr_width;
    wire [3:0] o_protect_range_bits;
    wire [2:0] o_secure_area_lock_bits;
    wire [1:0] o_output_drive_level;

    spi_host_model spi_host_model_i (.o_sclk(sclk), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso));
    flash_status_config_regs flash_status_config_regs_i (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_sclk(sclk), .i_cs_n(cs_n), .i_mosi(mosi),
        .o_miso(miso), .o_miso_oe(), .i_wp_n(i_wp_n), .i_dev_rst_n(i_dev_rst_n),
        .i_array_busy(i_array_busy), .i_array_req(i_array_req),
        .i_array_overlap(i_array_overlap), .o_array_go(o_array_go), .o_block_lock_preset(),
        .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
        .o_protect_range_bits(o_protect_range_bits), .o_top_bottom_select(o_top_bottom_select),
        .o_complement_protect(o_complement_protect),
        .o_protect_scheme_select(o_protect_scheme_select),
        .o_quad_enable_bit(o_quad_enable_bit), .o_secure_area_lock_bits(o_secure_area_lock_bits),
        .o_pause_state_flag(o_pause_state_flag), .o_current_addr_width(o_current_addr_width),
        .o_powerup_addr_width(o_powerup_addr_width), .o_output_drive_level(o_output_drive_level)
    );

    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end

    task automatic end_of_test;
        $display("mismatches %0d comparisons %0d", err_count, compares);
        if (err_count == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic reset;
        @(posedge i_mclk);
        i_srst <= 1'b1;
        repeat (2) @(posedge i_mclk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_mclk);
    endtask
    task automatic cmd(input logic [7:0] op);
        spi_host_model_i.frame({op, 16'h0000}, 8, rx);
    endtask
    task automatic rdchk(input logic [7:0] op, input logic [7:0] exp);
        spi_host_model_i.frame({op, 16'h0000}, 24, rx);
        chk(rx[15:8], exp);
        chk(rx[7:0], rx[15:8]);
    endtask
    task automatic wait_idle;
        int n;
        n = 0;
        while (o_busy !== 1'b0 && n < 1000) begin
            @(posedge i_mclk);
            n++;
        end
        if (n == 1000) begin
            err_count++;
            end_of_test();
        end
    endtask
    // latch, write, then wait out the busy time
    task automatic wr(input logic [7:0] op, input logic [7:0] d);
        cmd(8'h06);
        spi_host_model_i.frame({op, d, 8'h00}, 16, rx);
        wait_idle();
    endtask
    task automatic pulse(input logic ov, input logic exp_go);
        @(posedge i_mclk);
        i_array_overlap <= ov;
        i_array_req <= 1'b1;
        @(posedge i_mclk);
        i_array_req <= 1'b0;
        #1;
        chk(o_array_go, exp_go);
    endtask

    initial begin
        err_count = 0;
        compares = 0;
        i_srst = 1'b1;
        i_wp_n = 1'b1;
        i_dev_rst_n = 1'b1;
        i_array_busy = 1'b0;
        i_array_req = 1'b0;
        i_array_overlap = 1'b0;
        reset();
        rdchk(8'h05, 8'h00);
        rdchk(8'h35, 8'h00);
        rdchk(8'h15, 8'h60);
        spi_host_model_i.frame({8'h01, 8'h3C, 8'h00}, 16, rx);
        rdchk(8'h05, 8'h00);
        cmd(8'h06);
        rdchk(8'h05, 8'h02);
        cmd(8'h04);
        rdchk(8'h05, 8'h00);
        cmd(8'h06);
        spi_host_model_i.frame({8'h01, 8'h7C, 8'h00}, 16, rx);
        chk(o_busy, 1'b1);
        cmd(8'h06);
        rdchk(8'h05, 8'h7D);
        wait_idle();
        rdchk(8'h05, 8'h7C);
        chk({o_top_bottom_select, o_protect_range_bits}, 5'h1F);
        wr(8'h31, 8'h4A);
        rdchk(8'h35, 8'h4A);
        chk({o_complement_protect, o_quad_enable_bit, o_secure_area_lock_bits}, 5'h19);
        wr(8'h31, 8'h00);
        rdchk(8'h35, 8'h08);
        for (int d = 0; d < 4; d++) begin
            wr(8'h11, {1'b0, d[1:0], 5'h07});
            rdchk(8'h15, {1'b0, d[1:0], 5'h06});
            chk(o_output_drive_level, d[1:0]);
        end
        chk({o_protect_scheme_select, o_powerup_addr_width, o_current_addr_width}, 3'h6);
        cmd(8'hB7);
        rdchk(8'h15, 8'h67);
        cmd(8'hE9);
        rdchk(8'h15, 8'h66);
        @(posedge i_mclk);
        i_dev_rst_n <= 1'b0;
        repeat (4) @(posedge i_mclk);
        i_dev_rst_n <= 1'b1;
        repeat (8) @(posedge i_mclk);
        chk(o_current_addr_width, 1'b1);
        cmd(8'hE9);
        // suspend only acts while an operation is running
        @(posedge i_mclk);
        i_array_busy <= 1'b1;
        cmd(8'h75);
        rdchk(8'h35, 8'h88);
        @(posedge i_mclk);
        i_array_busy <= 1'b0;
        wait_idle();
        cmd(8'h7A);
        rdchk(8'h35, 8'h08);
        wr(8'h01, 8'h80);
        rdchk(8'h05, 8'h80);
        @(posedge i_mclk);
        i_wp_n <= 1'b0;
        wr(8'h01, 8'h84);
        rdchk(8'h05, 8'h82);
        @(posedge i_mclk);
        i_wp_n <= 1'b1;
        wr(8'h01, 8'h84);
        rdchk(8'h05, 8'h84);
        cmd(8'h06);
        pulse(1'b1, 1'b0);
        pulse(1'b0, 1'b1);
        chk(o_write_enable_latch, 1'b0);
        @(posedge i_mclk);
        i_array_busy <= 1'b1;
        cmd(8'h06);
        rdchk(8'h05, 8'h85);
        @(posedge i_mclk);
        i_array_busy <= 1'b0;
        wait_idle();
        wr(8'h31, 8'h09);
        wr(8'h01, 8'h00);
        rdchk(8'h05, 8'h86);
        reset();
        rdchk(8'h35, 8'h00);
        end_of_test();
    end
endmodule
